// ### design/pscl_defs.svh
// constant definitions for the strap configuration latch
`ifndef PSCL_DEFS_SVH
`define PSCL_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets on apb
// ----------------------------------------------------------------
`define PSCL_OFF_STATUS    12'h000
`define PSCL_OFF_CONFIG    12'h004
`define PSCL_OFF_CTRL      12'h008
`define PSCL_OFF_LED       12'h00c

// ----------------------------------------------------------------
// field positions in status / config
// ----------------------------------------------------------------
`define PSCL_BIT_IN_RESET   0
`define PSCL_BIT_MIDSPAN    0
`define PSCL_BIT_LEGACY     1
`define PSCL_BIT_DC_DISC    2
`define PSCL_BIT_TWO_EVENT  3
`define PSCL_BIT_PWM        4
`define PSCL_BIT_LSC        5
`define PSCL_BIT_HI_CLASS   6
`define PSCL_LSB_LIMSEL     7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PSCL_RST_STRAPS     6'h3f
`define PSCL_RST_CTRL       1'h0
`define PSCL_RST_LED        2'h0

// ----------------------------------------------------------------
// timing: minimum enable-low time and pwm figures
// ----------------------------------------------------------------
`define PSCL_CLK_MHZ        100
`define PSCL_EN_LOW_US      40
`define PSCL_EN_LOW_CYC     (`PSCL_EN_LOW_US * `PSCL_CLK_MHZ)
`define PSCL_SETTLE_CYC     3'h5
`define PSCL_PWM_KHZ        25
`define PSCL_PWM_PERIOD_CYC ((`PSCL_CLK_MHZ * 1000) / `PSCL_PWM_KHZ)
`define PSCL_PWM_ON_CYC     (`PSCL_PWM_PERIOD_CYC / 16)
`define PSCL_BLINK_CYC      24'h4c4b40

`endif

// ### design/pscl_pkg.sv
// types shared by the strap configuration latch
package pscl_pkg;

  // reset sequencer states
  typedef enum logic [1:0]
  {
    PSCL_ST_RESET   = 2'b00,
    PSCL_ST_CAPTURE = 2'b01,
    PSCL_ST_RUN     = 2'b10
  } pscl_state_t;

  // indicator pattern set by software
  typedef enum logic [1:0]
  {
    PSCL_LED_OFF   = 2'b00,
    PSCL_LED_ON    = 2'b01,
    PSCL_LED_BLINK = 2'b10,
    PSCL_LED_FAST  = 2'b11
  } pscl_led_t;

endpackage : pscl_pkg

// ### design/pscl_strap_latch.sv
// strap sampling, reset timing, config latch, indicator and apb slave
//
// Overview of operation
// - both limit straps jointly pick high class
// - floating straps read high through pull-ups
// - two-event select low enables two-event
// - pwm strap high drives indicator from pwm
// - stability strap high enables stability check
// - midspan strap high enables collision avoidance
// - legacy strap high enables high-cap detection
// - enable low 40 us resets the device
// - enable rising edge captures seven straps
// - midspan level latched after power-up or reset
// - legacy level latched after power-up or reset
// - oscillator pin low selects dc disconnect
// - open-drain indicator blinks distinct patterns
// - both limit straps floating disables high class
// - strap changes other than pwm ignored outside reset
`timescale 1ns/1ps
`include "pscl_defs.svh"

module pscl_strap_latch
(
  input  wire logic        pclk,                  // 100 mhz clock
  input  wire logic        presetn,               // async power-up reset
  input  wire logic        psel,                  // apb select
  input  wire logic        penable,               // apb access phase
  input  wire logic        pwrite,                // apb direction
  input  wire logic [11:0] paddr,                 // apb byte address
  input  wire logic [31:0] pwdata,                // apb write data
  output logic      [31:0] prdata,                // apb read data
  output logic             pready,                // apb ready
  output logic             pslverr,               // apb error
  input  wire logic        enable_n,              // active-low enable pin
  input  wire logic        hi_class_limit_sel_a,  // limit strap a
  input  wire logic        hi_class_limit_sel_b,  // limit strap b
  input  wire logic        two_event_sel_n,       // low enables two-event
  input  wire logic        indicator_pwm_enable,  // pwm strap
  input  wire logic        load_stability_check_enable, // stability strap
  input  wire logic        midspan_sel,           // collision avoidance strap
  input  wire logic        legacy_sel,            // high-cap strap
  input  wire logic        disconnect_mode_sel,   // oscillator pin level
  output logic             core_reset_q,          // reset from the sequencer
  output logic             midspan_en_q,          // collision avoidance active
  output logic             legacy_en_q,           // high-cap detection active
  output logic             dc_disconnect_q,       // dc disconnect selected
  output logic             ac_disconnect_q,       // ac disconnect selected
  output logic             two_event_en_q,        // two-event active
  output logic             lsc_en_q,              // stability check active
  output logic             hi_class_en_q,         // extra class enabled
  output logic      [1:0]  hi_class_limit_q,      // extra class limit code
  output logic             led_drive_q,           // indicator drive level, held low
  output logic             led_oe_q               // open-drain enable
);

  // ----------------------------------------------------------------
  // pin synchronisers: three stages, change seen when 2 and 3 agree
  // ----------------------------------------------------------------
  localparam int NPIN = 9;
  logic [NPIN-1:0] pin_raw;       // raw pins
  logic [NPIN-1:0] sync1_q;       // first stage, read by sync2 only
  logic [NPIN-1:0] sync2_q;       // second stage
  logic [NPIN-1:0] sync3_q;       // third stage
  logic [NPIN-1:0] pin_q;         // filtered level
  logic [NPIN-1:0] pin_d;         // next filtered level

  // unconnected pins float high through the pad pull-ups
  assign pin_raw = {enable_n, disconnect_mode_sel, legacy_sel, midspan_sel,
                    load_stability_check_enable, indicator_pwm_enable,
                    two_event_sel_n, hi_class_limit_sel_b,
                    hi_class_limit_sel_a};

  // accept a new level only when two late stages agree; while they
  // differ the old level is kept, so a pin caught mid-edge never flickers
  assign pin_d = (sync2_q & sync3_q) | (pin_q & (sync2_q ^ sync3_q));

  // synchroniser chain, reset to the pulled-up level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= '1;
      sync2_q <= '1;
      sync3_q <= '1;
      pin_q   <= '1;
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q   <= pin_d;
    end
  end

  wire en_level = pin_q[8];       // filtered enable

  // ----------------------------------------------------------------
  // enable low-time counter
  // ----------------------------------------------------------------
  localparam logic [12:0] EN_LOW_CYC = 13'(`PSCL_EN_LOW_CYC);
  logic [12:0] low_cnt_q;         // consecutive low samples
  logic [12:0] low_cnt_d;
  wire         low_long = (low_cnt_q >= EN_LOW_CYC);

  // count saturates; any high sample restarts it
  assign low_cnt_d = en_level ? 13'h0000 :
                     (low_long ? low_cnt_q : low_cnt_q + 13'h0001);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_cnt_q <= 13'h0000;
    else
      low_cnt_q <= low_cnt_d;
  end

  // ----------------------------------------------------------------
  // power-up settle: the filter shows the pads only after a few clocks
  // ----------------------------------------------------------------
  localparam logic [2:0] SETTLE_CYC = `PSCL_SETTLE_CYC;
  logic [2:0] settle_q;           // clocks since power-up, saturating
  logic [2:0] settle_d;           // next settle count
  wire        settled = (settle_q == SETTLE_CYC);

  // without this wait the first capture would take the reset
  // value of the filter instead of the real strap levels
  assign settle_d = settled ? settle_q : settle_q + 3'h1;

  // settle counter, cleared only by power-up reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_q <= 3'h0;
    else
      settle_q <= settle_d;
  end

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  pscl_pkg::pscl_state_t state_q;  // current state
  pscl_pkg::pscl_state_t state_d;  // next state
  logic                  sw_reset_q; // software-held reset

  // power-up starts in reset; capture happens on the way out
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      pscl_pkg::PSCL_ST_RESET:
        // leave on enable high, the low-to-high edge of reset
        if (en_level && !sw_reset_q && settled)
          state_d = pscl_pkg::PSCL_ST_CAPTURE;
      pscl_pkg::PSCL_ST_CAPTURE:
        // one clock in capture, then run
        state_d = pscl_pkg::PSCL_ST_RUN;
      pscl_pkg::PSCL_ST_RUN:
        // short glitches under 40 us do not reset
        if (low_long || sw_reset_q)
          state_d = pscl_pkg::PSCL_ST_RESET;
      default:
        state_d = pscl_pkg::PSCL_ST_RESET;
    endcase
  end

  // one-cycle strobe; the latch below takes the pins only here
  wire capture = (state_q == pscl_pkg::PSCL_ST_CAPTURE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q      <= pscl_pkg::PSCL_ST_RESET;
      core_reset_q <= 1'b1;
    end
    else
    begin
      state_q      <= state_d;
      core_reset_q <= (state_d != pscl_pkg::PSCL_ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // configuration latch: straps only taken on reset exit
  // ----------------------------------------------------------------
  wire both_float = pin_q[0] & pin_q[1];
  // the latch stores the stapped levels; outside capture it holds
  // reset values match the pulled-up defaults of the straps except the disconnect pair, which resets to dc
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      midspan_en_q     <= 1'b1;
      legacy_en_q      <= 1'b1;
      dc_disconnect_q  <= 1'b1;
      ac_disconnect_q  <= 1'b0;
      two_event_en_q   <= 1'b0;
      lsc_en_q         <= 1'b1;
      hi_class_en_q    <= 1'b0;
      hi_class_limit_q <= 2'h3;
    end
    else if (capture)
    begin
      midspan_en_q     <= pin_q[5];
      legacy_en_q      <= pin_q[6];
      // a capacitor leaves the oscillator pin high: ac; tied low: dc
      dc_disconnect_q  <= ~pin_q[7];
      ac_disconnect_q  <= pin_q[7];
      two_event_en_q   <= ~pin_q[2];
      lsc_en_q         <= pin_q[4];
      hi_class_en_q    <= ~both_float;
      hi_class_limit_q <= {pin_q[1], pin_q[0]};
    end
  end

  // ----------------------------------------------------------------
  // indicator: open-drain, pwm gated, blink patterns
  // ----------------------------------------------------------------
  localparam logic [11:0] PWM_PER = 12'(`PSCL_PWM_PERIOD_CYC);
  localparam logic [11:0] PWM_ON  = 12'(`PSCL_PWM_ON_CYC);
  localparam logic [23:0] BLINK   = `PSCL_BLINK_CYC;
  logic [11:0] pwm_cnt_q;         // pwm phase
  logic [23:0] blink_cnt_q;       // blink phase
  logic        pwm_en_q;          // pwm strap, live level
  pscl_pkg::pscl_led_t led_mode_q; // pattern set by software

  wire pwm_wrap   = (pwm_cnt_q == PWM_PER - 12'h001);
  wire blink_wrap = (blink_cnt_q == BLINK - 24'h000001);
  wire pwm_on     = (pwm_cnt_q < PWM_ON) | ~pwm_en_q;
  wire pat_on     = (led_mode_q == pscl_pkg::PSCL_LED_ON) ||
                    // slow blink uses bit 22: the count wraps before bit 23 sets
                    (led_mode_q == pscl_pkg::PSCL_LED_BLINK && blink_cnt_q[22]) ||
                    (led_mode_q == pscl_pkg::PSCL_LED_FAST && blink_cnt_q[21]);
  wire led_d      = pat_on & pwm_on & ~core_reset_q;

  // counters free-run; the pin only sinks, never drives high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_cnt_q   <= 12'h000;
      blink_cnt_q <= 24'h000000;
      pwm_en_q    <= 1'b1;
      led_drive_q <= 1'b0;
      led_oe_q    <= 1'b0;
    end
    else
    begin
      pwm_cnt_q   <= pwm_wrap ? 12'h000 : pwm_cnt_q + 12'h001;
      blink_cnt_q <= blink_wrap ? 24'h000000 : blink_cnt_q + 24'h000001;
      pwm_en_q    <= pin_q[3];
      led_drive_q <= 1'b0;
      led_oe_q    <= led_d;
    end
  end

  // ----------------------------------------------------------------
  // apb slave: zero wait, unmapped reads zero with pslverr
  // ----------------------------------------------------------------
  wire access  = psel & penable;
  wire sel_st  = (paddr == `PSCL_OFF_STATUS);
  wire sel_cfg = (paddr == `PSCL_OFF_CONFIG);
  wire sel_ctl = (paddr == `PSCL_OFF_CTRL);
  wire sel_led = (paddr == `PSCL_OFF_LED);
  wire mapped  = sel_st | sel_cfg | sel_ctl | sel_led;
  wire [31:0] cfg_word = {23'h000000, hi_class_limit_q, hi_class_en_q, lsc_en_q,
                          pwm_en_q, two_event_en_q, dc_disconnect_q,
                          legacy_en_q, midspan_en_q};
  wire [31:0] rd_mux = sel_st  ? {31'h00000000, core_reset_q} :
                       sel_cfg ? cfg_word :
                       sel_ctl ? {31'h00000000, sw_reset_q} :
                       sel_led ? {30'h00000000, led_mode_q} : 32'h00000000;

  // pready stays high; one access phase per transfer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata     <= 32'h00000000;
      pready     <= 1'b1;
      pslverr    <= 1'b0;
      sw_reset_q <= `PSCL_RST_CTRL;
      led_mode_q <= pscl_pkg::PSCL_LED_OFF;
    end
    else
    begin
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
      pready  <= 1'b1;
      pslverr <= psel & ~penable & ~mapped;
      // register writes take effect in the access phase only
      if (access && pwrite && sel_ctl)
        sw_reset_q <= pwdata[0];
      if (access && pwrite && sel_led)
        led_mode_q <= pscl_pkg::pscl_led_t'(pwdata[1:0]);
    end
  end

endmodule : pscl_strap_latch

// ### verification/pscl_strap_latch_assertions.sv
// concurrent checks on the strap latch ports
`timescale 1ns/1ps
module pscl_strap_latch_assertions
(
  input wire logic pclk,                        // system clock
  input wire logic presetn,                     // async reset, low active
  input wire logic enable_n,                    // enable pin
  input wire logic hi_class_limit_sel_a,        // limit strap a
  input wire logic hi_class_limit_sel_b,        // limit strap b
  input wire logic two_event_sel_n,             // two-event strap
  input wire logic load_stability_check_enable, // stability strap
  input wire logic midspan_sel,                 // midspan strap
  input wire logic legacy_sel,                  // high-cap strap
  input wire logic disconnect_mode_sel,         // oscillator pin level
  input wire logic core_reset_q,                // device in reset
  input wire logic midspan_en_q,                // latched midspan
  input wire logic legacy_en_q,                 // latched legacy
  input wire logic dc_disconnect_q,             // dc disconnect
  input wire logic ac_disconnect_q,             // ac disconnect
  input wire logic two_event_en_q,              // latched two-event
  input wire logic lsc_en_q,                    // latched stability
  input wire logic hi_class_en_q,               // latched high class
  input wire logic led_drive_q,                 // indicator drive
  input wire logic led_oe_q                     // indicator sink enable
);
  // ----------------------------------------------------------------
  // helper: consecutive raw low cycles of the enable pin
  // ----------------------------------------------------------------
  logic [12:0] low_cnt_q; // saturates, so a long hold never wraps
  logic [12:0] low_cnt_d; // next count
  assign low_cnt_d = enable_n ? 13'h0 : low_cnt_q + {12'h0, low_cnt_q != 13'h1fff};
  // count update
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) low_cnt_q <= 13'h0;
    else low_cnt_q <= low_cnt_d;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // reset timing and latched configuration
  // ----------------------------------------------------------------
  a_reset_entry: assert property (low_cnt_q == 13'd4020 |-> core_reset_q)
    else $error("enable held low but no reset");
  a_reset_filter: assert property ($rose(core_reset_q) |-> low_cnt_q >= 13'd3990)
    else $error("reset entered on a short low pulse");
  a_reset_exit: assert property ($rose(enable_n) && core_reset_q |-> ##[1:20] !core_reset_q)
    else $error("reset not left after enable rose");
  a_cfg_hold: assert property (!core_reset_q && !$past(core_reset_q) |-> $stable({midspan_en_q,
    legacy_en_q, dc_disconnect_q, two_event_en_q, lsc_en_q, hi_class_en_q}))
    else $error("config changed outside reset");
  a_fall_mid: assert property ($fell(core_reset_q) |-> midspan_en_q == midspan_sel)
    else $error("midspan not captured");
  a_fall_leg: assert property ($fell(core_reset_q) |-> legacy_en_q == legacy_sel)
    else $error("legacy not captured");
  a_fall_two: assert property ($fell(core_reset_q) |-> two_event_en_q != two_event_sel_n)
    else $error("two-event not captured");
  a_fall_lsc: assert property ($fell(core_reset_q) |->
    lsc_en_q == load_stability_check_enable)
    else $error("stability check not captured");
  a_fall_hi: assert property ($fell(core_reset_q) |->
    hi_class_en_q == !(hi_class_limit_sel_a && hi_class_limit_sel_b))
    else $error("high class enable wrong");
  a_disc_pair: assert property (dc_disconnect_q != ac_disconnect_q)
    else $error("disconnect modes not exclusive");
  a_led_sink: assert property (!led_drive_q)
    else $error("open-drain pin driven high");
  a_fall_disc: assert property ($fell(core_reset_q) |->
    dc_disconnect_q == !disconnect_mode_sel)
    else $error("disconnect mode not captured");
  a_led_dark: assert property (core_reset_q && $past(core_reset_q) |-> !led_oe_q)
    else $error("indicator sinking during reset");
endmodule : pscl_strap_latch_assertions

// ### verification/pscl_strap_host.sv
// board straps and enable driver facing the strap latch
`timescale 1ns/1ps
module pscl_strap_host
(
  input  wire logic       pclk,         // system clock
  input  wire logic       core_reset_q, // device reset state
  input  wire logic [7:0] req_straps,   // wanted levels, 1 = left floating
  input  wire logic       req_en_n,     // wanted enable, 1 = floating
  output logic      [7:0] straps,       // {a,b,two_n,pwm,lsc,mid,leg,disc}
  output logic            enable_n      // enable pin level
);
  logic [7:0] pin_q = 8'hff; // all straps floating at power-up
  // a floating pin reads high through its pull-up, so level equals request
  // two-event and stability straps only move while the device is in reset
  always @(posedge pclk)
    pin_q <= core_reset_q ? req_straps :
             {req_straps[7:6], pin_q[5], req_straps[4], pin_q[3], req_straps[2:0]};
  assign straps   = pin_q;
  assign enable_n = req_en_n;
endmodule : pscl_strap_host

// ### verification/pse_strap_config_latch_test.sv
// self-checking bench for the strap latch
`timescale 1ns/1ps
module pse_strap_config_latch_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0; // bench drive
  logic [11:0] paddr = 12'h0;   // apb address
  logic [31:0] pwdata = 32'h0;  // apb write data
  logic [31:0] prdata, rd;      // read data, last taken
  logic        pready, pslverr, err, enable_n, req_en_n = 1;
  logic        core_reset_q, midspan_en_q, legacy_en_q, dc_disconnect_q, ac_disconnect_q;
  logic        two_event_en_q, lsc_en_q, hi_class_en_q, led_drive_q, led_oe_q;
  logic [1:0]  hi_class_limit_q; // latched limit code
  logic [7:0]  req = 8'hff, pins, s; // strap requests, levels, chosen set
  integer      seed = 32'h6523, miscompares = 0, comparisons = 0, k, i, n;

  always #5 pclk = ~pclk; // 100 mhz

  pscl_strap_host host (.pclk(pclk), .core_reset_q(core_reset_q), .req_straps(req),
    .req_en_n(req_en_n), .straps(pins), .enable_n(enable_n));
  pscl_strap_latch uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enable_n(enable_n), .hi_class_limit_sel_a(pins[7]),
    .hi_class_limit_sel_b(pins[6]), .two_event_sel_n(pins[5]), .indicator_pwm_enable(pins[4]),
    .load_stability_check_enable(pins[3]), .midspan_sel(pins[2]), .legacy_sel(pins[1]),
    .disconnect_mode_sel(pins[0]), .core_reset_q(core_reset_q), .midspan_en_q(midspan_en_q),
    .legacy_en_q(legacy_en_q), .dc_disconnect_q(dc_disconnect_q),
    .ac_disconnect_q(ac_disconnect_q), .two_event_en_q(two_event_en_q), .lsc_en_q(lsc_en_q),
    .hi_class_en_q(hi_class_en_q), .hi_class_limit_q(hi_class_limit_q),
    .led_drive_q(led_drive_q), .led_oe_q(led_oe_q));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : check

  // config bits {limit, hi, lsc, pwm, two, dc, leg, mid}; pwm follows the live strap
  function logic [8:0] exp_cfg(input logic [7:0] v, input logic pwm);
    return {v[6], v[7], ~(v[7] & v[6]), v[3], pwm, ~v[5], ~v[0], v[1], v[2]};
  endfunction : exp_cfg

  // one apb transfer; read data and error taken at the ready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer i;
    logic   ok;
    ok = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 50 && !ok; i++)
    begin
      @(posedge pclk);
      ok = (pready === 1'b1);
    end
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    if (!ok) begin miscompares++; test_done(); end
  endtask : apb

  // bounded wait for the device to leave reset
  task wait_run;
    integer i;
    for (i = 0; i < 200 && core_reset_q !== 1'b0; i++) @(posedge pclk);
    if (core_reset_q !== 1'b0) begin miscompares++; test_done(); end
  endtask : wait_run

  task cfg_check(input logic [7:0] v);
    logic [8:0] e;
    e = exp_cfg(v, req[4]);
    check("ports", {23'h0, ~e[2], e[8:5], e[3:0]},
      {23'h0, ac_disconnect_q, hi_class_limit_q, hi_class_en_q, lsc_en_q, two_event_en_q,
      dc_disconnect_q, legacy_en_q, midspan_en_q});
    apb(0, 12'h004, 32'h0);
    check("config", {23'h0, e}, rd & 32'h1ff);
  endtask : cfg_check

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge pclk);
    check("reset held", 1, core_reset_q);
    presetn <= 1;
    wait_run();
    cfg_check(8'hff);
    apb(0, 12'h010, 32'h0);
    check("unmapped err", 1, err);
    check("unmapped data", 0, rd);
    // indicator on: steady with the pwm strap low, 1 in 16 of 4000 with it high
    apb(1, 12'h00c, 32'h1);
    apb(0, 12'h00c, 32'h0);
    check("led mode", 1, rd);
    check("led err", 0, err);
    req <= 8'hef;
    repeat (20) @(posedge pclk);
    check("led steady", 1, led_oe_q);
    req <= 8'hff;
    repeat (20) @(posedge pclk);
    n = 0;
    for (i = 0; i < 4000; i++)
    begin
      @(posedge pclk);
      n += led_oe_q;
    end
    check("led pwm", 100000 / 25 / 16, n);
    // corner sets first, then random ones, each through a full reset
    for (k = 0; k < 4; k++)
    begin
      s = (k == 0) ? 8'h00 : (k == 1) ? 8'h7f : 8'($random(seed));
      req_en_n <= 0;
      repeat (4030) @(posedge pclk);
      check("reset entry", 1, core_reset_q);
      req <= s;
      repeat (5) @(posedge pclk);
      req_en_n <= 1;
      wait_run();
      cfg_check(s);
      req <= ~s;
      repeat (30) @(posedge pclk);
      cfg_check(s);
    end
    // a short low pulse must not reset the device
    req_en_n <= 0;
    repeat (3990) @(posedge pclk);
    req_en_n <= 1;
    repeat (10) @(posedge pclk);
    check("short pulse", 0, core_reset_q);
    apb(0, 12'h000, 32'h0);
    check("status", 0, rd & 32'h1);
    apb(0, 12'h008, 32'h0);
    check("ctrl", 0, rd);
    apb(1, 12'h00c, 32'h0);
    repeat (3) @(posedge pclk);
    check("led off", 0, led_oe_q);
    test_done();
  end
endmodule : pse_strap_config_latch_test

bind pscl_strap_latch pscl_strap_latch_assertions chk (.pclk, .presetn, .enable_n,
  .hi_class_limit_sel_a, .hi_class_limit_sel_b, .two_event_sel_n,
  .load_stability_check_enable, .midspan_sel, .legacy_sel, .disconnect_mode_sel,
  .core_reset_q, .midspan_en_q, .legacy_en_q, .dc_disconnect_q, .ac_disconnect_q,
  .two_event_en_q, .lsc_en_q, .hi_class_en_q, .led_drive_q, .led_oe_q);
